// file: common/io_port_cfg.svh
`ifndef IO_PORT_CFG_SVH
`define IO_PORT_CFG_SVH
`define OFS_PORT_A_PIN_LEVELS 8'h00
`define OFS_PORT_B_PIN_LEVELS 8'h01
`define OFS_PORT_A_CONTROL 8'h02
`define OFS_PORT_B_CONTROL 8'h03
`define OFS_PORT_A_OUTPUT_LEVELS 8'h04
`define OFS_PORT_B_OUTPUT_LEVELS 8'h05
`define OFS_PORT_A_PIN_DIRECTION 8'h06
`define OFS_PORT_B_PIN_DIRECTION 8'h07
`define OFS_PORT_C_PIN_LEVELS 8'h10
`define OFS_PORT_D_PIN_LEVELS 8'h11
`define OFS_PORT_C_OUTPUT_LEVELS 8'h12
`define OFS_PORT_D_OUTPUT_LEVELS 8'h13
`define OFS_PORT_C_PIN_DIRECTION 8'h14
`define OFS_PORT_D_PIN_DIRECTION 8'h15
`define RST_PORT_REG 8'h00
`define PORT_C_IMPL_MASK 8'h9C
`define PORT_D_IMPL_MASK_FULL 8'h06
`define PORT_D_IMPL_MASK_SMALL 8'h02
`define PORT_C_SECOND_GROUP_MASK 8'h9C
`define PORT_C_STATUS_BIT 3
`define PORT_C_ERROR_BIT 4
`define UNIMPL_READ_FILL 8'h00
`endif

// file: common/io_port_pkg.sv
package io_port_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C, PORT_D} port_id_e;
endpackage

// file: design/reset_sync.sv
`timescale 1ns/10ps
module reset_sync
(
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic syncRst_n
);
  logic stage_q;

  // Release is synchronised so that no register leaves reset on a different edge from its neighbours.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_q <= 1'b0;
      syncRst_n <= 1'b0;
    end
    else
    begin
      stage_q <= 1'b1;
      syncRst_n <= stage_q;
    end
  end
endmodule

// file: design/io_pin_lane.sv
`timescale 1ns/10ps
module io_pin_lane
#(
  parameter int WIDTH = 8
)
(
  input wire logic [WIDTH-1:0] outputLevels,
  input wire logic [WIDTH-1:0] pinDirection,
  input wire logic [WIDTH-1:0] altSelect,
  input wire logic [WIDTH-1:0] altData,
  input wire logic [WIDTH-1:0] logicOutSelect,
  input wire logic [WIDTH-1:0] logicOutData,
  input wire logic [WIDTH-1:0] logicOeTerm,
  input wire logic [WIDTH-1:0] implMask,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe_n
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      // A logic-array output takes priority over every register-driven source.
      always_comb
      begin
        if (logicOutSelect[i])
          pinOut[i] = logicOutData[i]; // R17
        else if (altSelect[i])
          pinOut[i] = altData[i];
        else
          pinOut[i] = outputLevels[i]; // R02
      end

      // A macrocell-driven pin ignores its direction bit; unimplemented pins never drive.
      always_comb
      begin
        if (!implMask[i])
          pinOe_n[i] = 1'b1; // R18
        else if (logicOutSelect[i])
          pinOe_n[i] = ~logicOeTerm[i]; // R09
        else
          pinOe_n[i] = ~(logicOeTerm[i] | pinDirection[i]); // R01 R16
      end
    end
  endgenerate
endmodule

// file: design/mcu_io_port_registers.sv
// Function
// R01: Direction bit one makes the pin an output, zero an input.
// R02: In processor mode an output pin follows its data-out bit.
// R03: Data-in reads return the present sampled pin levels.
// R04: Port A and B data-out registers reset to zero.
// R05: Port A direction and port D data-out reset to zero.
// R06: Unimplemented data-in bits of ports C and D are undefined.
// R07: Port D uses bits 2 and 1 only; bit 2 absent on small package.
// R08: Software leaves control bits zero for processor I/O mode.
// R09: Direction bit has no effect on a macrocell-driven pin.
// R10: Software sets memory-map control bit 7 for repeater mode.
// R11: Port C pins 0, 1, 5, 6 are dedicated scan-test pins.
// R12: Six-pin programming mode puts status on C3 and error on C4.
// R13: Second macrocell group reaches only port C pins 2, 3, 4, 7.
// R14: Direction bits rewritable anytime; ports allow mixed directions.
// R15: Control bit one selects latched address output on ports A and B.
// R16: Pin output enable is logic-array enable OR direction bit.
// R17: Data-out register has no effect on a logic-array output pin.
// R18: Writes to unimplemented bits are ignored.
`timescale 1ns/10ps
`include "io_port_cfg.svh"
module mcu_io_port_registers
#(
  parameter bit LARGE_PACKAGE = 1'b1
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire io_port_pkg::byte_t regWdata,
  output io_port_pkg::byte_t regRdata,
  input wire logic peripheral_repeater_enable,
  input wire logic [7:0] latchedAddrA,
  input wire logic [7:0] latchedAddrB,
  input wire logic [7:0] repeaterDataA,
  input wire logic [7:0] repeaterOeA,
  input wire logic [7:0] outputMacrocellSelA,
  input wire logic [7:0] outputMacrocellDataA,
  input wire logic [7:0] outputMacrocellSelB,
  input wire logic [7:0] outputMacrocellDataB,
  input wire logic [7:0] second_macrocell_group_sel,
  input wire logic [7:0] second_macrocell_group_data,
  input wire logic [7:0] general_logic_array_oe_a,
  input wire logic [7:0] general_logic_array_oe_b,
  input wire logic [7:0] general_logic_array_oe_c,
  input wire logic [7:0] decode_logic_array_sel_d,
  input wire logic [7:0] decode_logic_array_data_d,
  input wire logic [7:0] decode_logic_array_oe_d,
  input wire logic sixPinProgramMode,
  input wire logic program_status_out,
  input wire logic program_error_out,
  input wire logic [7:0] portAIn,
  output logic [7:0] portAOut,
  output logic [7:0] portAOe_n,
  input wire logic [7:0] portBIn,
  output logic [7:0] portBOut,
  output logic [7:0] portBOe_n,
  input wire logic [7:0] portCIn,
  output logic [7:0] portCOut,
  output logic [7:0] portCOe_n,
  input wire logic [7:0] portDIn,
  output logic [7:0] portDOut,
  output logic [7:0] portDOe_n
);
  import io_port_pkg::*;

  logic syncRst_n;
  byte_t outA_q;
  byte_t outB_q;
  byte_t outC_q;
  byte_t outD_q;
  byte_t dirA_q;
  byte_t dirB_q;
  byte_t dirC_q;
  byte_t dirD_q;
  byte_t ctlA_q;
  byte_t ctlB_q;
  byte_t pinA_q;
  byte_t pinB_q;
  byte_t pinC_q;
  byte_t pinD_q;
  byte_t rdata_d;
  byte_t maskD;
  byte_t selC;
  byte_t dataC;
  byte_t dirCEff;
  byte_t oeCTerm;
  byte_t altSelA;
  byte_t altDataA;
  byte_t oeATerm;

  // Pins with no bonded pad must never be written or driven.
  function automatic byte_t impl_mask(input port_id_e port);
    begin
      unique case (port)
        PORT_A: impl_mask = LARGE_PACKAGE ? 8'hFF : 8'h00;
        PORT_B: impl_mask = 8'hFF;
        PORT_C: impl_mask = `PORT_C_IMPL_MASK; // R11
        PORT_D: impl_mask = LARGE_PACKAGE ? `PORT_D_IMPL_MASK_FULL : `PORT_D_IMPL_MASK_SMALL; // R07
      endcase
    end
  endfunction

  assign maskD = impl_mask(PORT_D);

  reset_sync u_reset_sync
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .syncRst_n(syncRst_n)
  );

  // Pins are registered once; the read then costs one cycle of latency but sees a clean level.
  always_ff @(posedge sys_clk or negedge syncRst_n)
  begin
    if (!syncRst_n)
    begin
      pinA_q <= `RST_PORT_REG;
      pinB_q <= `RST_PORT_REG;
      pinC_q <= `RST_PORT_REG;
      pinD_q <= `RST_PORT_REG;
    end
    else
    begin
      pinA_q <= portAIn; // R03
      pinB_q <= portBIn;
      pinC_q <= portCIn;
      pinD_q <= portDIn;
    end
  end

  always_ff @(posedge sys_clk or negedge syncRst_n)
  begin
    if (!syncRst_n)
    begin
      outA_q <= `RST_PORT_REG; // R04
      outB_q <= `RST_PORT_REG; // R04
      outC_q <= `RST_PORT_REG;
      outD_q <= `RST_PORT_REG; // R05
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `OFS_PORT_A_OUTPUT_LEVELS: outA_q <= regWdata & impl_mask(PORT_A); // R18
        `OFS_PORT_B_OUTPUT_LEVELS: outB_q <= regWdata & impl_mask(PORT_B);
        `OFS_PORT_C_OUTPUT_LEVELS: outC_q <= regWdata & impl_mask(PORT_C); // R18
        `OFS_PORT_D_OUTPUT_LEVELS: outD_q <= regWdata & maskD; // R18
        default: ;
      endcase
    end
  end

  // Direction may change at any time, per bit.
  always_ff @(posedge sys_clk or negedge syncRst_n)
  begin
    if (!syncRst_n)
    begin
      dirA_q <= `RST_PORT_REG; // R05
      dirB_q <= `RST_PORT_REG;
      dirC_q <= `RST_PORT_REG;
      dirD_q <= `RST_PORT_REG;
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `OFS_PORT_A_PIN_DIRECTION: dirA_q <= regWdata & impl_mask(PORT_A); // R14
        `OFS_PORT_B_PIN_DIRECTION: dirB_q <= regWdata & impl_mask(PORT_B); // R14
        `OFS_PORT_C_PIN_DIRECTION: dirC_q <= regWdata & impl_mask(PORT_C); // R18
        `OFS_PORT_D_PIN_DIRECTION: dirD_q <= regWdata & maskD; // R18
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge syncRst_n)
  begin
    if (!syncRst_n)
    begin
      ctlA_q <= `RST_PORT_REG; // R08
      ctlB_q <= `RST_PORT_REG; // R08
    end
    else if (regWrite)
    begin
      unique case (regAddr)
        `OFS_PORT_A_CONTROL: ctlA_q <= regWdata & impl_mask(PORT_A); // R15
        `OFS_PORT_B_CONTROL: ctlB_q <= regWdata; // R15
        default: ;
      endcase
    end
  end

  // Unimplemented data-in bits read a fixed fill, which software must not rely on.
  always_comb
  begin
    rdata_d = `RST_PORT_REG;
    unique case (regAddr)
      `OFS_PORT_A_PIN_LEVELS: rdata_d = pinA_q & impl_mask(PORT_A); // R03
      `OFS_PORT_B_PIN_LEVELS: rdata_d = pinB_q; // R03
      `OFS_PORT_C_PIN_LEVELS: rdata_d = (pinC_q & impl_mask(PORT_C)) | (`UNIMPL_READ_FILL & ~impl_mask(PORT_C)); // R06
      `OFS_PORT_D_PIN_LEVELS: rdata_d = (pinD_q & maskD) | (`UNIMPL_READ_FILL & ~maskD); // R06 R07
      `OFS_PORT_A_CONTROL: rdata_d = ctlA_q;
      `OFS_PORT_B_CONTROL: rdata_d = ctlB_q;
      `OFS_PORT_A_OUTPUT_LEVELS: rdata_d = outA_q;
      `OFS_PORT_B_OUTPUT_LEVELS: rdata_d = outB_q;
      `OFS_PORT_C_OUTPUT_LEVELS: rdata_d = outC_q;
      `OFS_PORT_D_OUTPUT_LEVELS: rdata_d = outD_q;
      `OFS_PORT_A_PIN_DIRECTION: rdata_d = dirA_q;
      `OFS_PORT_B_PIN_DIRECTION: rdata_d = dirB_q;
      `OFS_PORT_C_PIN_DIRECTION: rdata_d = dirC_q;
      `OFS_PORT_D_PIN_DIRECTION: rdata_d = dirD_q;
      default: rdata_d = `RST_PORT_REG;
    endcase
  end

  // Read data is held until the next read, so a slow master may still pick it up late.
  always_ff @(posedge sys_clk or negedge syncRst_n)
  begin
    if (!syncRst_n)
      regRdata <= `RST_PORT_REG;
    else if (regRead)
      regRdata <= rdata_d;
  end

  // Port A: latched address per control bit, or the repeater when its enable is set.
  always_comb
  begin
    if (peripheral_repeater_enable) // R10
    begin
      altSelA = 8'hFF;
      altDataA = repeaterDataA;
      oeATerm = general_logic_array_oe_a | repeaterOeA;
    end
    else
    begin
      altSelA = ctlA_q; // R15
      altDataA = latchedAddrA;
      oeATerm = general_logic_array_oe_a;
    end
  end

  // Port C: the data-out register, the second macrocell group and the programming outputs drive it.
  // Programming outputs win so that a stray logic equation cannot block programming.
  always_comb
  begin
    selC = second_macrocell_group_sel & `PORT_C_SECOND_GROUP_MASK; // R13
    dataC = second_macrocell_group_data;
    oeCTerm = general_logic_array_oe_c;
    dirCEff = dirC_q;
    if (sixPinProgramMode)
    begin
      selC[`PORT_C_STATUS_BIT] = 1'b1; // R12
      selC[`PORT_C_ERROR_BIT] = 1'b1; // R12
      dataC[`PORT_C_STATUS_BIT] = program_status_out;
      dataC[`PORT_C_ERROR_BIT] = program_error_out;
      oeCTerm[`PORT_C_STATUS_BIT] = 1'b1;
      oeCTerm[`PORT_C_ERROR_BIT] = 1'b1;
    end
  end

  io_pin_lane #(.WIDTH(8)) u_lane_a
  (
    .outputLevels(outA_q),
    .pinDirection(dirA_q),
    .altSelect(altSelA),
    .altData(altDataA),
    .logicOutSelect(outputMacrocellSelA),
    .logicOutData(outputMacrocellDataA),
    .logicOeTerm(oeATerm),
    .implMask(impl_mask(PORT_A)),
    .pinOut(portAOut),
    .pinOe_n(portAOe_n)
  );

  io_pin_lane #(.WIDTH(8)) u_lane_b
  (
    .outputLevels(outB_q),
    .pinDirection(dirB_q),
    .altSelect(ctlB_q),
    .altData(latchedAddrB),
    .logicOutSelect(outputMacrocellSelB),
    .logicOutData(outputMacrocellDataB),
    .logicOeTerm(general_logic_array_oe_b),
    .implMask(impl_mask(PORT_B)),
    .pinOut(portBOut),
    .pinOe_n(portBOe_n)
  );

  io_pin_lane #(.WIDTH(8)) u_lane_c
  (
    .outputLevels(outC_q),
    .pinDirection(dirCEff),
    .altSelect(8'h00),
    .altData(8'h00),
    .logicOutSelect(selC),
    .logicOutData(dataC),
    .logicOeTerm(oeCTerm),
    .implMask(impl_mask(PORT_C)),
    .pinOut(portCOut),
    .pinOe_n(portCOe_n)
  );

  io_pin_lane #(.WIDTH(8)) u_lane_d
  (
    .outputLevels(outD_q),
    .pinDirection(dirD_q),
    .altSelect(8'h00),
    .altData(8'h00),
    .logicOutSelect(decode_logic_array_sel_d & maskD),
    .logicOutData(decode_logic_array_data_d),
    .logicOeTerm(decode_logic_array_oe_d & maskD),
    .implMask(maskD),
    .pinOut(portDOut),
    .pinOe_n(portDOe_n)
  );
endmodule

// file: tb/io_board_model.sv
`timescale 1ns/10ps
module io_board_model
(
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe_n,
  input wire logic [7:0] extLevel,
  output logic [7:0] pinLevel
);
  // The device wins where it drives; elsewhere the board holds its own level, so nothing floats to a lucky zero.
  assign pinLevel = (pinOut & ~pinOe_n) | (extLevel & pinOe_n);
endmodule

// file: tb/mcu_io_port_registers_asserts.sv
`timescale 1ns/10ps
module mcu_io_port_registers_asserts
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire io_port_pkg::byte_t regWdata,
  input wire io_port_pkg::byte_t regRdata,
  input wire logic peripheral_repeater_enable,
  input wire logic [7:0] outputMacrocellSelA,
  input wire logic [7:0] general_logic_array_oe_a,
  input wire logic [7:0] outputMacrocellSelB,
  input wire logic [7:0] outputMacrocellDataB,
  input wire logic [7:0] general_logic_array_oe_b,
  input wire logic [7:0] second_macrocell_group_data,
  input wire logic [7:0] second_macrocell_group_sel,
  input wire logic sixPinProgramMode,
  input wire logic program_status_out,
  input wire logic program_error_out,
  input wire logic [7:0] portAOut,
  input wire logic [7:0] portAOe_n,
  input wire logic [7:0] portBOut,
  input wire logic [7:0] portBOe_n,
  input wire logic [7:0] portCOut,
  input wire logic [7:0] portCOe_n
);
  import io_port_pkg::*;
  logic quietA;
  logic [7:0] ctlAMirror;
  // Pins handed to the latched address no longer follow the data-out register.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctlAMirror <= 8'h00;
    else if (regWrite && regAddr == 8'h02)
      ctlAMirror <= regWdata;
  end
  // Port A checks only hold while no override path owns the pins.
  assign quietA = !peripheral_repeater_enable && outputMacrocellSelA == 8'h00 && general_logic_array_oe_a == 8'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_dir_sets_oe: assert property (regWrite && regAddr == 8'h06 && quietA |=> !quietA || portAOe_n == ~$past(regWdata))
    else $error("port A enables do not follow direction write");
  a_out_drives_pin: assert property (regWrite && regAddr == 8'h04 && quietA |=>
    !quietA || ((portAOut ^ $past(regWdata)) & ~portAOe_n & ~ctlAMirror) == 8'h00)
    else $error("port A pin data does not follow data-out write");
  a_scan_pins_off: assert property ((portCOe_n & 8'h63) == 8'h63)
    else $error("scan-test pin driven");
  a_oe_term_or: assert property ((general_logic_array_oe_b & portBOe_n) == 8'h00)
    else $error("logic-array enable did not enable pin");
  a_dir_ignored: assert property ((outputMacrocellSelB & ~general_logic_array_oe_b & ~portBOe_n) == 8'h00)
    else $error("direction enabled a macrocell pin");
  a_macro_data_b: assert property (((portBOut ^ outputMacrocellDataB) & outputMacrocellSelB & ~portBOe_n) == 8'h00)
    else $error("macrocell pin shows other data");
  a_group_c_data: assert property (!sixPinProgramMode |->
    ((portCOut ^ second_macrocell_group_data) & second_macrocell_group_sel & ~portCOe_n & 8'h9C) == 8'h00)
    else $error("second group data wrong on port C");
  a_prog_pins: assert property (sixPinProgramMode |->
    portCOe_n[4:3] == 2'b00 && portCOut[4:3] == {program_error_out, program_status_out})
    else $error("programming status pins wrong");
  a_unmapped_read: assert property (regRead && regAddr == 8'h20 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!regRead |=> $stable(regRdata))
    else $error("read data changed without a read");
endmodule
bind mcu_io_port_registers mcu_io_port_registers_asserts mcu_io_port_registers_asserts_inst (.sys_clk, .rst_n,
  .regWrite, .regRead, .regAddr, .regWdata, .regRdata, .peripheral_repeater_enable, .outputMacrocellSelA,
  .general_logic_array_oe_a, .outputMacrocellSelB, .outputMacrocellDataB, .general_logic_array_oe_b,
  .second_macrocell_group_data, .second_macrocell_group_sel, .sixPinProgramMode, .program_status_out,
  .program_error_out, .portAOut, .portAOe_n, .portBOut, .portBOe_n, .portCOut, .portCOe_n);

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  import io_port_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n, regWrite, regRead, peripheral_repeater_enable, sixPinProgramMode, program_status_out, program_error_out;
  logic [7:0] regAddr, latchedAddrA, latchedAddrB, repeaterDataA, repeaterOeA, outputMacrocellSelA;
  logic [7:0] outputMacrocellDataA, outputMacrocellSelB, outputMacrocellDataB, second_macrocell_group_sel;
  logic [7:0] second_macrocell_group_data, general_logic_array_oe_a, general_logic_array_oe_b, general_logic_array_oe_c;
  logic [7:0] decode_logic_array_sel_d, decode_logic_array_data_d, decode_logic_array_oe_d, extA, extB, extC, extD;
  logic [7:0] portAIn, portAOut, portAOe_n, portBIn, portBOut, portBOe_n, portCIn, portCOut, portCOe_n;
  logic [7:0] portDIn, portDOut, portDOe_n;
  byte_t regWdata, regRdata;
  int failCount = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  mcu_io_port_registers mcu_io_port_registers_inst (.sys_clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
    .regRdata, .peripheral_repeater_enable, .latchedAddrA, .latchedAddrB, .repeaterDataA, .repeaterOeA,
    .outputMacrocellSelA, .outputMacrocellDataA, .outputMacrocellSelB, .outputMacrocellDataB,
    .second_macrocell_group_sel, .second_macrocell_group_data, .general_logic_array_oe_a, .general_logic_array_oe_b,
    .general_logic_array_oe_c, .decode_logic_array_sel_d, .decode_logic_array_data_d, .decode_logic_array_oe_d,
    .sixPinProgramMode, .program_status_out, .program_error_out, .portAIn, .portAOut, .portAOe_n, .portBIn,
    .portBOut, .portBOe_n, .portCIn, .portCOut, .portCOe_n, .portDIn, .portDOut, .portDOe_n);
  io_board_model boardA_inst (.pinOut(portAOut), .pinOe_n(portAOe_n), .extLevel(extA), .pinLevel(portAIn));
  io_board_model boardB_inst (.pinOut(portBOut), .pinOe_n(portBOe_n), .extLevel(extB), .pinLevel(portBIn));
  io_board_model boardC_inst (.pinOut(portCOut), .pinOe_n(portCOe_n), .extLevel(extC), .pinLevel(portCIn));
  io_board_model boardD_inst (.pinOut(portDOut), .pinOe_n(portDOe_n), .extLevel(extD), .pinLevel(portDIn));
  task automatic chk(input byte_t got, input byte_t exp);
    comparisons++;
    if (got !== exp)
    begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input byte_t d);
    @(negedge sys_clk);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge sys_clk);
    regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input byte_t exp, input byte_t m);
    @(negedge sys_clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRead = 1'b0;
    chk(regRdata & m, exp);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #20us;
    failCount++;
    end_sim();
  end
  initial
  begin
    {rst_n, regWrite, regRead, sixPinProgramMode, program_status_out, program_error_out, regAddr, regWdata} = '0;
    peripheral_repeater_enable = 1'b0;
    {latchedAddrA, latchedAddrB, repeaterDataA, repeaterOeA, outputMacrocellSelA, outputMacrocellDataA} = '0;
    {outputMacrocellSelB, outputMacrocellDataB, second_macrocell_group_sel, second_macrocell_group_data} = '0;
    {general_logic_array_oe_a, general_logic_array_oe_b, general_logic_array_oe_c} = '0;
    {decode_logic_array_sel_d, decode_logic_array_data_d, decode_logic_array_oe_d} = '0;
    {extA, extB, extC, extD} = {8'h3C, 8'h5A, 8'h00, 8'hFF};
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    rd(8'h04, 8'h00, 8'hFF);
    rd(8'h05, 8'h00, 8'hFF);
    rd(8'h06, 8'h00, 8'hFF);
    rd(8'h13, 8'h00, 8'hFF);
    chk(portAOe_n, 8'hFF);
    $display("test reset_values done");
    wr(8'h06, 8'h0F);
    wr(8'h04, 8'hA5);
    chk(portAOe_n, 8'hF0);
    rd(8'h00, 8'h35, 8'hFF);
    wr(8'h06, 8'hF0);
    rd(8'h00, 8'hAC, 8'hFF);
    rd(8'h06, 8'hF0, 8'hFF);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h5A, 8'hFF);
    $display("test mcu_io done");
    wr(8'h14, 8'hFF);
    wr(8'h12, 8'hFF);
    chk(portCOe_n, 8'h63);
    rd(8'h14, 8'h9C, 8'hFF);
    rd(8'h10, 8'h9C, 8'h9C);
    wr(8'h15, 8'hFF);
    wr(8'h13, 8'hFD);
    chk(portDOe_n, 8'hF9);
    rd(8'h13, 8'h04, 8'hFF);
    rd(8'h11, 8'h04, 8'h06);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00, 8'hFF);
    $display("test masks done");
    general_logic_array_oe_b = 8'h01;
    outputMacrocellSelB = 8'h03;
    outputMacrocellDataB = 8'h03;
    latchedAddrB = 8'h80;
    wr(8'h03, 8'h80);
    wr(8'h07, 8'h82);
    chk(portBOe_n & 8'h83, 8'h02);
    chk(portBOut & 8'h81, 8'h81);
    latchedAddrA = 8'h01;
    wr(8'h02, 8'h01);
    chk(portAOut & 8'h0F, 8'h05);
    {peripheral_repeater_enable, repeaterDataA, repeaterOeA} = {1'b1, 8'h96, 8'h03};
    {decode_logic_array_sel_d, decode_logic_array_oe_d} = {8'hFF, 8'h02};
    @(negedge sys_clk);
    chk(portAOut, 8'h96);
    chk(portAOe_n, 8'h0C);
    chk(portDOut & 8'h06, 8'h00);
    chk(portDOe_n, 8'hFD);
    peripheral_repeater_enable = 1'b0;
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h00, 8'hFF);
    $display("test logic_paths done");
    second_macrocell_group_sel = 8'hFF;
    second_macrocell_group_data = 8'hFF;
    general_logic_array_oe_c = 8'h84;
    wr(8'h14, 8'h00);
    chk(portCOe_n, 8'h7B);
    chk(portCOut & 8'h84, 8'h84);
    sixPinProgramMode = 1'b1;
    program_status_out = 1'b1;
    @(negedge sys_clk);
    chk(portCOe_n & 8'h18, 8'h00);
    chk(portCOut & 8'h18, 8'h08);
    $display("test port_c_modes done");
    end_sim();
  end
endmodule
